// File: rx_port_model.sv
// partner model: receive port presenting up to three tags per frame
`timescale 1ns/1ns
module rx_port_model (
    input  wire logic   clk,
    output logic        frame_valid,
    output logic [15:0] etype0,
    output logic [15:0] tci0,
    output logic [15:0] etype1,
    output logic [15:0] tci1,
    output logic [15:0] etype2,
    output logic [15:0] tci2
);
    initial begin
        frame_valid = 1'b0;
        {etype0, tci0, etype1, tci1, etype2, tci2} = '0;
    end
    task automatic send(input logic [95:0] tags);
        @(posedge clk);
        frame_valid <= 1'b1;
        {etype0, tci0, etype1, tci1, etype2, tci2} <= tags;
        @(posedge clk);
        frame_valid <= 1'b0;
        // released fields no longer show the frame
        {etype0, tci0, etype1, tci1, etype2, tci2} <= ~tags;
    endtask : send
endmodule : rx_port_model

// File: tb_top.sv
// testbench: register access, tag classification and lag code checks
`timescale 1ns/1ns
module tb_top;
    logic         clk, resetn, psel, penable, pwrite, pready, pslverr, re;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic         frame_valid, result_valid, is_ipv4, is_ipv6, has_l4;
    logic [15:0]  etype0, tci0, etype1, tci1, etype2, tci2, sport, dport;
    logic [47:0]  dmac, smac;
    logic [19:0]  flow_label;
    logic [127:0] sip, dip;
    logic [11:0]  service_index, class_vid;
    logic         has_stack_hdr, class_dei, priority_tagged, arrived_tagged;
    logic [3:0]   stack_code, lag_code;
    logic [2:0]   class_pcp, tag_kind;
    logic [1:0]   pop_field;
    int           err_total, total_checks;
    vlan_classify_and_lag_code u_vlan_classify_and_lag_code (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frame_valid(frame_valid),
        .etype0(etype0), .tci0(tci0), .etype1(etype1), .tci1(tci1),
        .etype2(etype2), .tci2(tci2), .dmac(dmac), .smac(smac),
        .is_ipv4(is_ipv4), .is_ipv6(is_ipv6), .flow_label(flow_label),
        .sip(sip), .dip(dip), .has_l4(has_l4), .sport(sport), .dport(dport),
        .service_index(service_index), .has_stack_hdr(has_stack_hdr),
        .stack_code(stack_code), .result_valid(result_valid),
        .class_pcp(class_pcp), .class_dei(class_dei), .class_vid(class_vid),
        .tag_kind(tag_kind), .priority_tagged(priority_tagged),
        .pop_field(pop_field), .arrived_tagged(arrived_tagged),
        .lag_code(lag_code));
    rx_port_model u_rx_port_model (
        .clk(clk), .frame_valid(frame_valid), .etype0(etype0), .tci0(tci0),
        .etype1(etype1), .tci1(tci1), .etype2(etype2), .tci2(tci2));
    ////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic fr(input logic [15:0] e0, t0, e1, t1, e2, t2);
        u_rx_port_model.send({e0, t0, e1, t1, e2, t2});
        #1;
    endtask : fr
    task automatic cls(input logic [2:0] k, p, input logic d,
                       input logic [11:0] v, input logic [1:0] c, input logic a);
        logic [20:0] got;
        got = {tag_kind, class_pcp, class_dei, class_vid, pop_field};
        chk(result_valid, 1'b1);
        chk({got, arrived_tagged}, {k, p, d, v, c, a});
    endtask : cls
    function automatic logic [3:0] fold(input logic [127:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < 32; i++) r ^= v[4*i +: 4];
        return r;
    endfunction : fold
    ////////////////////////////////////////
    task automatic t_reset;
        apb(0, vlan_lag_pkg::port_vlan_control_addr, 0);
        chk(rd, 32'h0000_0001);
        apb(0, vlan_lag_pkg::valid_tpid_mask_addr, 0);
        chk(rd, 32'h0000_001F);
        apb(0, 8'h40, 0);
        chk({re, rd}, {1'b1, 32'h0000_0000});
        fr(16'h0800, 16'h2011, 0, 0, 0, 0);
        cls(0, 0, 0, 12'h001, 0, 0);
    endtask : t_reset
    task automatic t_kinds;
        logic [15:0] tp [5];
        tp = '{16'h8100, 16'h88A8, 16'h9100, 16'h9200, 16'h9300};
        apb(1, vlan_lag_pkg::custom_stag_tpid0_addr, 32'h0000_9100);
        apb(1, vlan_lag_pkg::custom_stag_tpid1_addr, 32'h0000_9200);
        apb(1, vlan_lag_pkg::custom_stag_tpid2_addr, 32'h0000_9300);
        apb(1, vlan_lag_pkg::port_vlan_control_addr, 32'h0008_000A);
        for (int i = 0; i < 5; i++) begin
            fr(tp[i], 16'hB123, 16'h0800, 0, 0, 0);
            cls(i + 1, 5, 1, 12'h123, 0, 1);
            chk(priority_tagged, 1'b0);
        end
        fr(16'h8100, 16'h6000, 16'h0800, 0, 0, 0);
        cls(1, 3, 0, 0, 0, 1);
        chk(priority_tagged, 1'b1);
    endtask : t_kinds
    task automatic t_stop;
        apb(1, vlan_lag_pkg::valid_tpid_mask_addr, 32'h0000_001D);
        apb(1, vlan_lag_pkg::port_vlan_control_addr, 32'h000F_2007);
        fr(16'h8100, 16'h2011, 16'h88A8, 16'h4022, 16'h8100, 16'h6033);
        cls(1, 1, 0, 12'h011, 1, 1);
        fr(16'h8100, 16'h2011, 16'h8100, 16'h4022, 16'h8100, 16'h6033);
        cls(1, 2, 0, 12'h022, 3, 1);
        fr(16'h88A8, 16'h2011, 16'h8100, 16'h4022, 0, 0);
        cls(0, 2, 0, 12'h007, 0, 0);
        apb(1, vlan_lag_pkg::port_vlan_control_addr, 32'h0007_2007);
        fr(16'h8100, 16'h2011, 16'h0800, 0, 0, 0);
        cls(1, 1, 0, 12'h011, 1, 0);
        apb(0, vlan_lag_pkg::result_addr, 0);
        chk(rd, {10'h000, 1'b0, 2'd1, 3'd1, 3'd1, 1'b0, 12'h011});
    endtask : t_stop
    task automatic t_lag;
        logic [47:0] rv;
        logic [3:0]  e;
        rv = {<<{dmac}};
        for (int b = 0; b < 10; b++) begin
            case (b)
                0: e = fold(dmac);
                1: e = fold(rv);
                2: e = fold(smac);
                3: e = fold(flow_label);
                4: e = fold(sip) ^ fold(dip);
                5: e = fold(sport) ^ fold(dport);
                6: e = fold(service_index);
                7: e = fold(dmac) ^ fold(rv);
                default: e = fold(dmac) ^ fold(rv) ^ fold(smac) ^
                    fold(flow_label) ^ fold(sip) ^ fold(dip) ^ fold(sport) ^
                    fold(dport) ^ fold(service_index);
            endcase
            if (b == 9) e = stack_code;
            apb(1, vlan_lag_pkg::lag_code_config_addr,
                b < 7 ? 1 << b : (b == 7 ? 3 : (b == 8 ? 32'h7F : 32'h17F)));
            has_stack_hdr <= (b >= 8);
            fr(16'h0800, 0, 0, 0, 0, 0);
            chk(lag_code, e);
        end
        apb(0, vlan_lag_pkg::lag_result_addr, 0);
        chk(rd, {28'h000_0000, stack_code});
    endtask : t_lag
    task automatic t_rand;
        logic [3:0] first;
        logic       moved;
        moved = 1'b0;
        apb(1, vlan_lag_pkg::lag_code_config_addr, 32'h0000_0080);
        fr(16'h0800, 0, 0, 0, 0, 0);
        first = lag_code;
        for (int i = 0; i < 4; i++) begin
            fr(16'h0800, 0, 0, 0, 0, 0);
            moved = moved | (lag_code != first);
        end
        chk(moved, 1'b1);
    endtask : t_rand
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        err_total++;
        stop_test();
    end
    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata, is_ipv4} = '0;
        {has_stack_hdr, stack_code} = {1'b0, 4'hC};
        {dmac, smac} = {48'h1234_5678_9ABC, 48'h0F1E_2D3C_4B5A};
        {is_ipv6, has_l4, flow_label} = {2'b11, 20'hA_BCDE};
        {sip, dip} = {128'h2001_0DB8_0000_0000_0000_0000_0000_0001, 128'hF0E1};
        {sport, dport, service_index} = {16'h1F90, 16'h0050, 12'h5A3};
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_kinds();
        t_stop();
        t_lag();
        t_rand();
        stop_test();
    end
endmodule : tb_top

// File: vlan_classify_and_lag_code.sv
// vlan classification and link aggregation code generation
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - ethertype 0x8100 before a tag marks a customer tag
// - ethertype 0x88A8 before a tag marks a standard service tag
// - three programmable custom tpids also mark service tags
// - nonzero vid is a vlan tag, zero vid a priority tag
// - per-port mask picks which of five tpid types are valid
// - parsing stops at first invalid tpid; later tags ignored
// - classified tag from frame tag, else port defaults
// - inner select with two or more valid tags uses second tag
// - every frame gets pcp, dei, vid and tag kind
// - pop count is configured value limited to valid tag count
// - pop field never exceeds three
// - arrived_tagged only when port aware and a valid tag exists
// - reversed dmac maps bit 47 to bit 0 before folding
// - normal and reversed dmac enables act independently
// - smac lower 48 bits fold in when enabled
// - all 20 flow label bits fold in when enabled
// - all source and destination ip bits fold in when enabled
// - 16-bit l4 source and destination ports fold in when enabled
// - 12-bit service index after match stage folds in when enabled
// - 4-bit pseudo-random number folds in when enabled
// - enabled contributions xor to 4-bit code for 256 masks
// - stacking header code used directly when passthrough enabled
module vlan_classify_and_lag_code (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         frame_valid,
    input  wire logic [15:0]  etype0,
    input  wire logic [15:0]  tci0,
    input  wire logic [15:0]  etype1,
    input  wire logic [15:0]  tci1,
    input  wire logic [15:0]  etype2,
    input  wire logic [15:0]  tci2,
    input  wire logic [47:0]  dmac,
    input  wire logic [47:0]  smac,
    input  wire logic         is_ipv4,
    input  wire logic         is_ipv6,
    input  wire logic [19:0]  flow_label,
    input  wire logic [127:0] sip,
    input  wire logic [127:0] dip,
    input  wire logic         has_l4,
    input  wire logic [15:0]  sport,
    input  wire logic [15:0]  dport,
    input  wire logic [11:0]  service_index,
    input  wire logic         has_stack_hdr,
    input  wire logic [3:0]   stack_code,
    output logic              result_valid,
    output logic [2:0]        class_pcp,
    output logic              class_dei,
    output logic [11:0]       class_vid,
    output logic [2:0]        tag_kind,
    output logic              priority_tagged,
    output logic [1:0]        pop_field,
    output logic              arrived_tagged,
    output logic [3:0]        lag_code
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] port_vlan_control_q;
    logic [4:0]  valid_tpid_mask_q;
    logic [15:0] custom_stag_tpid_q [3];
    logic [8:0]  lag_code_config_q;
    logic [3:0]  lfsr_q;

    // fold a value into a nibble, zero-padding the top
    function automatic logic [3:0] fold128(input logic [127:0] v);
        logic [3:0] acc;
        acc = 4'h0;
        for (int i = 0; i < 32; i++) begin
            acc = acc ^ v[i*4 +: 4];
        end
        return acc;
    endfunction : fold128

    // tpid to kind (0..5)
    function automatic vlan_lag_pkg::tag_kind_e decode_tpid(
        input logic [15:0] et,
        input logic [15:0] c0,
        input logic [15:0] c1,
        input logic [15:0] c2
    );
        vlan_lag_pkg::tag_kind_e k;
        k = vlan_lag_pkg::kind_none;
        if (et == vlan_lag_pkg::ctag_tpid) begin
            k = vlan_lag_pkg::kind_ctag;
        end else if (et == vlan_lag_pkg::stag_tpid) begin
            k = vlan_lag_pkg::kind_stag;
        end else if (et == c0) begin
            k = vlan_lag_pkg::kind_cust0;
        end else if (et == c1) begin
            k = vlan_lag_pkg::kind_cust1;
        end else if (et == c2) begin
            k = vlan_lag_pkg::kind_cust2;
        end
        return k;
    endfunction : decode_tpid

    ////////////////////////////////////////////////////////////////////////
    // apb slave
    logic apb_wr;
    logic apb_rd;
    logic addr_ok;
    logic [31:0] rdata_d;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign pready = 1'b1;

    always_comb begin
        addr_ok = 1'b1;
        rdata_d = 32'h0000_0000;
        unique case (paddr)
            vlan_lag_pkg::port_vlan_control_addr:
                rdata_d = port_vlan_control_q & 32'h000F_FFFF;
            vlan_lag_pkg::valid_tpid_mask_addr:
                rdata_d = {27'h000_0000, valid_tpid_mask_q};
            vlan_lag_pkg::custom_stag_tpid0_addr:
                rdata_d = {16'h0000, custom_stag_tpid_q[0]};
            vlan_lag_pkg::custom_stag_tpid1_addr:
                rdata_d = {16'h0000, custom_stag_tpid_q[1]};
            vlan_lag_pkg::custom_stag_tpid2_addr:
                rdata_d = {16'h0000, custom_stag_tpid_q[2]};
            vlan_lag_pkg::lag_code_config_addr:
                rdata_d = {23'h00_0000, lag_code_config_q};
            vlan_lag_pkg::result_addr:
                rdata_d = {10'h000, arrived_tagged, pop_field, tag_kind,
                           class_pcp, class_dei, class_vid};
            vlan_lag_pkg::lag_result_addr:
                rdata_d = {28'h000_0000, lag_code};
            default:
                addr_ok = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !addr_ok;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_rd) begin
            prdata <= rdata_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            port_vlan_control_q  <= vlan_lag_pkg::pvc_reset;
            valid_tpid_mask_q    <= vlan_lag_pkg::tpid_mask_reset;
            custom_stag_tpid_q[0] <= vlan_lag_pkg::custom_tpid_reset;
            custom_stag_tpid_q[1] <= vlan_lag_pkg::custom_tpid_reset;
            custom_stag_tpid_q[2] <= vlan_lag_pkg::custom_tpid_reset;
            lag_code_config_q    <= 9'h000;
        end else if (apb_wr) begin
            unique case (paddr)
                vlan_lag_pkg::port_vlan_control_addr:
                    port_vlan_control_q <= pwdata & 32'h000F_FFFF;
                vlan_lag_pkg::valid_tpid_mask_addr:
                    valid_tpid_mask_q <= pwdata[4:0];
                vlan_lag_pkg::custom_stag_tpid0_addr:
                    custom_stag_tpid_q[0] <= pwdata[15:0];
                vlan_lag_pkg::custom_stag_tpid1_addr:
                    custom_stag_tpid_q[1] <= pwdata[15:0];
                vlan_lag_pkg::custom_stag_tpid2_addr:
                    custom_stag_tpid_q[2] <= pwdata[15:0];
                vlan_lag_pkg::lag_code_config_addr:
                    lag_code_config_q <= pwdata[8:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // tag parsing
    logic [15:0] et_a [3];
    logic [15:0] tci_a [3];
    vlan_lag_pkg::tag_kind_e kind_a [3];
    logic [2:0]  ok_a;
    logic [1:0]  n_valid;
    assign et_a[0] = etype0;
    assign et_a[1] = etype1;
    assign et_a[2] = etype2;
    assign tci_a[0] = tci0;
    assign tci_a[1] = tci1;
    assign tci_a[2] = tci2;

    for (genvar g = 0; g < vlan_lag_pkg::max_tags; g++) begin : g_tag
        logic in_mask;
        assign kind_a[g] = decode_tpid(et_a[g], custom_stag_tpid_q[0],
                                       custom_stag_tpid_q[1],
                                       custom_stag_tpid_q[2]);
        // mask bit i enables kind i+1
        assign in_mask = (kind_a[g] != vlan_lag_pkg::kind_none) &&
                         valid_tpid_mask_q[3'(kind_a[g]) - 3'd1];
        if (g == 0) begin : g_first
            assign ok_a[g] = in_mask;
        end else begin : g_rest
            assign ok_a[g] = in_mask && ok_a[g-1];
        end
    end

    // count of leading valid tags
    always_comb begin
        n_valid = 2'd0;
        if (ok_a[2]) begin
            n_valid = 2'd3;
        end else if (ok_a[1]) begin
            n_valid = 2'd2;
        end else if (ok_a[0]) begin
            n_valid = 2'd1;
        end
    end

    // selected tag
    logic        use_inner;
    logic [15:0] sel_tci;
    vlan_lag_pkg::tag_kind_e sel_kind;
    logic [1:0]  pop_cfg;
    logic [1:0]  pop_d;
    assign use_inner = port_vlan_control_q[vlan_lag_pkg::pvc_inner_bit]
                       && (n_valid >= 2'd2);
    assign sel_tci  = use_inner ? tci_a[1] : tci_a[0];
    assign sel_kind = use_inner ? kind_a[1] : kind_a[0];
    assign pop_cfg  = port_vlan_control_q[vlan_lag_pkg::pvc_pop_lsb +: 2];
    assign pop_d    = (pop_cfg > n_valid) ? n_valid : pop_cfg;

    ////////////////////////////////////////////////////////////////////////
    // lag code
    logic [47:0] dmac_rev;
    logic        is_ip;
    logic [3:0]  f_dmac;
    logic [3:0]  f_dmac_rev;
    logic [3:0]  f_smac;
    logic [3:0]  f_flow;
    logic [3:0]  f_ip;
    logic [3:0]  f_l4;
    logic [3:0]  f_service_index;
    logic [3:0]  fold_sum;
    logic [3:0]  lag_d;

    // bit 47 lands on bit 0
    for (genvar b = 0; b < 48; b++) begin : g_rev
        assign dmac_rev[b] = dmac[47 - b];
    end

    assign is_ip      = is_ipv4 || is_ipv6;
    assign f_dmac     = fold128({80'h0, dmac});
    assign f_dmac_rev = fold128({80'h0, dmac_rev});
    assign f_smac     = fold128({80'h0, smac});
    assign f_flow     = fold128({108'h0, flow_label});
    assign f_ip       = fold128(sip) ^ fold128(dip);
    assign f_l4       = fold128({96'h0, sport, dport});
    assign f_service_index     = fold128({116'h0, service_index});

    always_comb begin
        fold_sum = 4'h0;
        if (lag_code_config_q[vlan_lag_pkg::lcc_dmac_bit]) begin
            fold_sum = fold_sum ^ f_dmac;
        end
        if (lag_code_config_q[vlan_lag_pkg::lcc_dmacr_bit]) begin
            fold_sum = fold_sum ^ f_dmac_rev;
        end
        if (lag_code_config_q[vlan_lag_pkg::lcc_smac_bit]) begin
            fold_sum = fold_sum ^ f_smac;
        end
        if (lag_code_config_q[vlan_lag_pkg::lcc_flow_bit] && is_ipv6) begin
            fold_sum = fold_sum ^ f_flow;
        end
        if (lag_code_config_q[vlan_lag_pkg::lcc_ip_bit] && is_ip) begin
            fold_sum = fold_sum ^ f_ip;
        end
        if (lag_code_config_q[vlan_lag_pkg::lcc_l4_bit]
            && is_ip && has_l4) begin
            fold_sum = fold_sum ^ f_l4;
        end
        if (lag_code_config_q[vlan_lag_pkg::lcc_service_index_bit]) begin
            fold_sum = fold_sum ^ f_service_index;
        end
        if (lag_code_config_q[vlan_lag_pkg::lcc_rand_bit]) begin
            fold_sum = fold_sum ^ lfsr_q;
        end
        lag_d = fold_sum;
        if (lag_code_config_q[vlan_lag_pkg::lcc_stack_bit]
            && has_stack_hdr) begin
            lag_d = stack_code;
        end
    end

    // pseudo-random source, x^4+x^3+1
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lfsr_q <= vlan_lag_pkg::lfsr_seed;
        end else begin
            lfsr_q <= {lfsr_q[2:0], lfsr_q[3] ^ lfsr_q[2]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            result_valid <= 1'b0;
        end else begin
            result_valid <= frame_valid;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            class_pcp       <= 3'h0;
            class_dei       <= 1'b0;
            class_vid       <= 12'h000;
            tag_kind        <= 3'h0;
            priority_tagged <= 1'b0;
            pop_field       <= 2'h0;
            arrived_tagged  <= 1'b0;
            lag_code        <= 4'h0;
        end else if (frame_valid) begin
            if (n_valid != 2'd0) begin
                class_pcp <= sel_tci[15:13];
                class_dei <= sel_tci[12];
                class_vid <= sel_tci[11:0];
                tag_kind  <= 3'(sel_kind);
                priority_tagged <= (sel_tci[11:0] == 12'h000);
            end else begin
                class_pcp <= port_vlan_control_q[vlan_lag_pkg::pvc_pcp_lsb +: 3];
                class_dei <= port_vlan_control_q[vlan_lag_pkg::pvc_dei_bit];
                class_vid <= port_vlan_control_q[vlan_lag_pkg::pvc_vid_lsb +: 12];
                tag_kind  <= 3'(vlan_lag_pkg::kind_none);
                priority_tagged <= 1'b0;
            end
            pop_field <= pop_d;
            arrived_tagged <= port_vlan_control_q[vlan_lag_pkg::pvc_aware_bit]
                              && (n_valid != 2'd0);
            lag_code <= lag_d;
        end
    end
    // pop_field is 2 bits, so it can never exceed three
endmodule : vlan_classify_and_lag_code

// File: vlan_lag_checker.sv
// checker: port-level properties of the vlan and lag classifier
`timescale 1ns/1ns
module vlan_lag_checker (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        frame_valid,
    input wire logic        result_valid,
    input wire logic [11:0] class_vid,
    input wire logic [2:0]  tag_kind,
    input wire logic        priority_tagged,
    input wire logic [1:0]  pop_field,
    input wire logic        arrived_tagged
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_frame_in;
        frame_valid;
    endsequence
    sequence s_result;
        result_valid;
    endsequence
    a_result_pulse: assert property (s_frame_in |=> s_result)
        else $error("result pulse missing after frame");
    a_no_spurious: assert property (!frame_valid |=> !result_valid)
        else $error("result without frame");
    a_hold_class: assert property (!frame_valid |=> $stable(class_vid))
        else $error("class vid changed without frame");
    a_kind_range: assert property (tag_kind <= 3'h5)
        else $error("tag kind out of range");
    a_untag_pop: assert property (result_valid && tag_kind == 3'h0 |->
        pop_field == 2'h0 && !arrived_tagged)
        else $error("untagged frame with pop or tagged flag");
    a_tagged_kind: assert property (arrived_tagged |-> tag_kind != 3'h0)
        else $error("tagged flag without frame tag");
    a_prio_vid: assert property (priority_tagged |->
        class_vid == 12'h000 && tag_kind != 3'h0)
        else $error("priority tag with nonzero vid");
    a_vid_prio: assert property (result_valid && tag_kind != 3'h0 &&
        class_vid == 12'h000 |-> priority_tagged)
        else $error("zero vid tag not marked priority");
endmodule : vlan_lag_checker
bind vlan_classify_and_lag_code vlan_lag_checker u_vlan_lag_checker (
    .clk(clk), .resetn(resetn), .frame_valid(frame_valid),
    .result_valid(result_valid), .class_vid(class_vid),
    .tag_kind(tag_kind), .priority_tagged(priority_tagged),
    .pop_field(pop_field), .arrived_tagged(arrived_tagged));

// File: vlan_lag_pkg.sv
// package: register map, field layout and encodings for vlan/lag classifier
package vlan_lag_pkg;
    // apb register byte offsets
    localparam logic [7:0] port_vlan_control_addr = 8'h00;
    localparam logic [7:0] valid_tpid_mask_addr   = 8'h04;
    localparam logic [7:0] custom_stag_tpid0_addr = 8'h08;
    localparam logic [7:0] custom_stag_tpid1_addr = 8'h0C;
    localparam logic [7:0] custom_stag_tpid2_addr = 8'h10;
    localparam logic [7:0] lag_code_config_addr   = 8'h14;
    localparam logic [7:0] result_addr            = 8'h18;
    localparam logic [7:0] lag_result_addr        = 8'h1C;
    // port_vlan_control fields
    localparam int pvc_vid_lsb      = 0;
    localparam int pvc_pcp_lsb      = 12;
    localparam int pvc_dei_bit      = 15;
    localparam int pvc_inner_bit    = 16;
    localparam int pvc_pop_lsb      = 17;
    localparam int pvc_aware_bit    = 19;
    localparam logic [31:0] pvc_reset = 32'h0000_0001;
    // lag_code_config bits
    localparam int lcc_dmac_bit   = 0;
    localparam int lcc_dmacr_bit  = 1;
    localparam int lcc_smac_bit   = 2;
    localparam int lcc_flow_bit   = 3;
    localparam int lcc_ip_bit     = 4;
    localparam int lcc_l4_bit     = 5;
    localparam int lcc_service_index_bit   = 6;
    localparam int lcc_rand_bit   = 7;
    localparam int lcc_stack_bit  = 8;
    // tpid values and reset values
    localparam logic [15:0] ctag_tpid = 16'h8100;
    localparam logic [15:0] stag_tpid = 16'h88A8;
    localparam logic [15:0] custom_tpid_reset = 16'h0000;
    localparam logic [4:0]  tpid_mask_reset   = 5'h1F;
    localparam logic [3:0]  lfsr_seed         = 4'h1;
    localparam int          max_tags          = 3;
    // tag kind encoding carried in tag_kind
    typedef enum logic [2:0] {
        kind_none, kind_ctag, kind_stag, kind_cust0, kind_cust1, kind_cust2
    } tag_kind_e;
endpackage : vlan_lag_pkg
